// [pkg/prl_consts.vh]
// Constants for the program memory read limit block
`ifndef PRL_CONSTS_VH
`define PRL_CONSTS_VH
`define PRL_ADDR_W        16
`define PRL_DATA_W        8
`define PRL_BLOCKED_DATA  8'h00
`define PRL_LIMIT_LOW     8'h00
`define PRL_LOCK_W        8
`define PRL_LOCK_RESET    8'h00
`define PRL_PAGE_SHIFT    9
`define PRL_SEC_PAGE      7'h7E
`define PRL_PAGE_OFS      9'h000
`define PRL_ADDR_RESET    16'h0000
`define PRL_DATA_RESET    8'h00
`define PRL_RSV_START     16'hFE00
`define PRL_SEC_ADDR_LO   16'hFDFE
`define PRL_SEC_ADDR_HI   16'hFDFF
`endif

// [verif/prl_flash.sv]
// Flash array model, alternately prompt and slow
`timescale 1ns/100ps
module prl_flash (
  // Clock and read strobe from the block
  input  wire        sys_clk_i,
  input  wire        mem_rd_o,
  input  wire [15:0] mem_addr_o,
  // Answer towards the block
  output wire        mem_data_valid_i,
  output wire [7:0]  mem_data_i
);
  reg [1:0] sh = 2'b00;
  reg       slow = 1'b0;
  reg [7:0] a = 8'h00;
  always @(posedge sys_clk_i) begin
    sh <= {sh[0], mem_rd_o};
    if (mem_rd_o) {slow, a} <= {!slow, mem_addr_o[7:0]};
  end
  assign mem_data_valid_i = slow ? sh[0] : sh[1];
  // Inverted outside the valid cycle so stale data cannot pass
  assign mem_data_i = {8{!mem_data_valid_i}} ^ a ^ 8'h5A;
endmodule // prl_flash

// [verif/prl_read_limit_asserts.sv]
// Port checks for the read limit block
`timescale 1ns/100ps
module prl_chk (
  // Clock, reset, enable
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire        clk_en_i,
  // Read path
  input wire [7:0]  limit_byte_i,
  input wire        req_valid_i,
  input wire        req_is_table_i,
  input wire [15:0] req_pc_i,
  input wire [15:0] req_addr_i,
  input wire        mem_rd_o,
  input wire [7:0]  mem_data_i,
  input wire        mem_data_valid_i,
  input wire [7:0]  rd_data_o,
  input wire        rd_valid_o,
  input wire        rd_blocked_o,
  // Lock bits and debug erase
  input wire        lock_clr_i,
  input wire [7:0]  lock_wdata_i,
  input wire [7:0]  lock_rdata_o,
  input wire        dbg_erase_i,
  input wire [15:0] dbg_erase_addr_i,
  input wire        erase_all_o,
  input wire        erase_page_o,
  input wire [15:0] erase_page_addr_o,
  input wire        erase_err_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [15:0] lim = {limit_byte_i, 8'h00};
  wire blk = req_is_table_i && req_pc_i >= lim && req_addr_i < lim;
  AST_BLOCK: assert property ($rose(req_valid_i) && clk_en_i && blk
    |-> !mem_rd_o ##1 rd_valid_o && rd_blocked_o) else $error("blocked read");
  AST_ZERO: assert property (rd_blocked_o |-> rd_data_o == 8'h00) else $error("leak");
  AST_PASS: assert property ($rose(req_valid_i) && clk_en_i && !blk |-> mem_rd_o)
    else $error("no flash read");
  AST_DATA: assert property (mem_data_valid_i && clk_en_i
    |=> rd_valid_o && !rd_blocked_o && rd_data_o == $past(mem_data_i)) else $error("data");
  AST_CLR: assert property (lock_clr_i && !dbg_erase_i && clk_en_i
    |=> lock_rdata_o == ($past(lock_rdata_o) & $past(lock_wdata_i))) else $error("clear");
  AST_HOLD: assert property (!lock_clr_i && !dbg_erase_i |=> $stable(lock_rdata_o))
    else $error("lock moved");
  AST_ALL: assert property (dbg_erase_i && clk_en_i && dbg_erase_addr_i[15:1] == 15'h7EFF
    |=> erase_all_o && !erase_page_o && lock_rdata_o == 8'hFF) else $error("erase all");
  AST_PAGE: assert property (dbg_erase_i && clk_en_i && dbg_erase_addr_i[15:8] == 8'hFC
    |=> erase_page_o && erase_page_addr_o == 16'hFC00 && !erase_all_o && lock_rdata_o == 8'hFF)
    else $error("page");
  AST_ERR: assert property (dbg_erase_i && clk_en_i && dbg_erase_addr_i[15:9] == 7'h7F
    |=> erase_err_o && !erase_all_o && !erase_page_o) else $error("reserved erase");
endmodule // prl_chk
bind prl_read_limit prl_chk chk_u (.*);

// [verif/testbench.sv]
// Bench for the read limit block
`timescale 1ns/100ps
module testbench;
  reg sys_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_is_table_i = 0, lock_clr_i = 0;
  reg dbg_erase_i = 0, clk_en_i = 1, lock_set_i = 0;
  reg [7:0] limit_byte_i = 0, lock_wdata_i = 0;
  reg [15:0] req_pc_i = 0, req_addr_i = 0, dbg_erase_addr_i = 0;
  wire mem_rd_o, mem_data_valid_i, rd_valid_o, rd_blocked_o, erase_all_o, erase_page_o;
  wire erase_err_o;
  wire [7:0] mem_data_i, rd_data_o, lock_rdata_o;
  wire [15:0] mem_addr_o, erase_page_addr_o;
  integer miscompares = 0, cmp_count = 0, cyc = 0, n;
  always #2 sys_clk_i = ~sys_clk_i;
  prl_read_limit dut_u (.*);
  prl_flash fl_u (.*);
  task give_verdict;
    $display("cmp %0d miss %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  always @(posedge sys_clk_i) cyc++;
  always @(posedge sys_clk_i) if (cyc == 200) begin
    miscompares++;
    give_verdict;
  end
  task read(input [15:0] p, a, input t, b);
    {req_pc_i, req_addr_i, req_is_table_i, req_valid_i} <= {p, a, t, 1'b1};
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (rd_valid_o !== 1 && n < 9);
    req_valid_i <= 0;
    chk({rd_blocked_o, rd_data_o}, b ? 9'h100 : {1'b0, a[7:0] ^ 8'h5A});
    @(posedge sys_clk_i);
  endtask
  task poke(input c, input [15:0] a, input [7:0] w, input [26:0] e);
    {lock_set_i, lock_clr_i, dbg_erase_i, dbg_erase_addr_i, lock_wdata_i} <= {c, c, !c, a, w};
    @(posedge sys_clk_i);
    {lock_set_i, lock_clr_i, dbg_erase_i} <= 3'h0;
    @(posedge sys_clk_i);
    chk({erase_err_o, erase_all_o, erase_page_o, erase_page_addr_o & {16{erase_page_o}},
         lock_rdata_o}, e);
  endtask
  task s_reads;
    read(16'hFFFF, 16'h0012, 1, 0);
    limit_byte_i <= 8'h12; // Aligned to a 512-byte sector
    read(16'h1200, 16'h11FF, 1, 1);
    read(16'h1200, 16'h1200, 1, 0);
    read(16'h1300, 16'h0156, 0, 0);
    read(16'h11FF, 16'h0078, 1, 0);
  endtask
  task s_lock;
    chk(lock_rdata_o, 0);
    poke(0, 16'hFDFE, 0, {2'b10, 16'h0000, 8'hFF});
    poke(1, 0, 8'hF0, 26'h00F0);
    poke(1, 0, 8'hFF, 26'h00F0);
    poke(0, 16'h1234, 0, {2'b01, 16'h1200, 8'hF0});
    poke(0, 16'hFE10, 0, 27'h400_00F0);
    poke(0, 16'hFC10, 0, {2'b01, 16'hFC00, 8'hFF});
    clk_en_i <= 0;
    poke(1, 0, 8'h00, 26'h00FF);
    clk_en_i <= 1;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1;
    @(posedge sys_clk_i);
    s_reads;
    s_lock;
    give_verdict;
  end
endmodule // testbench

// [verilog/prl_read_limit.v]
// Read limit guard, lock bits and debug erase decode for program memory
`timescale 1ns/100ps
`include "prl_consts.vh"
module prl_read_limit #(
  parameter ADDR_W = `PRL_ADDR_W,
  parameter LOCK_W = `PRL_LOCK_W
) (
  // Clock, reset, enable
  input  wire              sys_clk_i,
  input  wire              rst_n_i,
  input  wire              clk_en_i,
  // Security byte holding the boundary high byte
  input  wire [7:0]        limit_byte_i,
  // Core request: fetch or table read
  input  wire              req_valid_i,
  input  wire              req_is_table_i,
  input  wire [ADDR_W-1:0] req_pc_i,
  input  wire [ADDR_W-1:0] req_addr_i,
  // Flash array
  output wire              mem_rd_o,
  output wire [ADDR_W-1:0] mem_addr_o,
  input  wire [7:0]        mem_data_i,
  input  wire              mem_data_valid_i,
  // Core answer
  output reg  [7:0]        rd_data_o,
  output reg               rd_valid_o,
  output reg               rd_blocked_o,
  // Lock bits: software view
  input  wire              lock_set_i,
  input  wire              lock_clr_i,
  input  wire [LOCK_W-1:0] lock_wdata_i,
  output wire [LOCK_W-1:0] lock_rdata_o,
  // Debug port erase
  input  wire              dbg_erase_i,
  input  wire [ADDR_W-1:0] dbg_erase_addr_i,
  output reg               erase_all_o,
  output reg               erase_page_o,
  output reg  [ADDR_W-1:0] erase_page_addr_o,
  output reg               erase_err_o
);
  // Fixed values of the read path
  localparam [7:0]        BLOCKED  = `PRL_BLOCKED_DATA;
  localparam [7:0]        LIM_LO   = `PRL_LIMIT_LOW;
  localparam [7:0]        DATA_RST = `PRL_DATA_RESET;

  // Fixed values of the erase decode and lock bits
  localparam [15:0]       SEC_LO   = `PRL_SEC_ADDR_LO;
  localparam [15:0]       SEC_HI   = `PRL_SEC_ADDR_HI;
  localparam [15:0]       RSV      = `PRL_RSV_START;
  localparam [15:0]       ADDR_RST = `PRL_ADDR_RESET;
  localparam [6:0]        SECPG    = `PRL_SEC_PAGE;
  localparam [8:0]        PG_OFS   = `PRL_PAGE_OFS;
  localparam [LOCK_W-1:0] LOCK_RST = `PRL_LOCK_RESET;

  // Read path states
  localparam [1:0]        ST_IDLE  = 2'h0;
  localparam [1:0]        ST_WAIT  = 2'h1;
  localparam [1:0]        ST_RESP  = 2'h2;

  // Read path
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [7:0]        next_rd_data;
  reg               next_rd_valid;
  reg               next_rd_blocked;
  wire [15:0]       boundary;
  wire              pc_upper;
  wire              tgt_lower;
  wire              block;
  wire              idle;

  // Lock bits and debug erase
  reg  [LOCK_W-1:0] lock;
  wire [LOCK_W-1:0] next_lock;
  wire              is_sec;
  wire              in_sec_page;
  wire              in_rsv;
  wire              erase_unlock;
  wire              fw_clear;
  wire [ADDR_W-1:0] page_base;
  reg               next_erase_all;
  reg               next_erase_page;
  reg               next_erase_err;
  reg  [ADDR_W-1:0] next_page_addr;

  // Zero byte gives boundary zero: everything upper-or-equal, nothing blocked
  assign boundary  = {limit_byte_i, LIM_LO};
  assign pc_upper  = (req_pc_i >= boundary);
  assign tgt_lower = (req_addr_i < boundary);
  // Only table reads are filtered; fetches pass so published entry points work
  assign block     = req_is_table_i & pc_upper & tgt_lower;
  assign idle      = (state == ST_IDLE);

  // Blocked reads never reach the array, so no lower contents leak on its bus
  assign mem_rd_o   = req_valid_i & ~block & idle & clk_en_i & rst_n_i;
  assign mem_addr_o = req_addr_i;

  // Answer register: blocked data and array data share one path
  always @* begin
    next_state      = state;
    next_rd_data    = rd_data_o;
    next_rd_valid   = 1'b0;
    next_rd_blocked = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid_i && block) begin
          next_state      = ST_RESP;
          next_rd_data    = BLOCKED;
          next_rd_valid   = 1'b1;
          next_rd_blocked = 1'b1;
        end else if (req_valid_i) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_data_valid_i) begin
          next_state    = ST_RESP;
          next_rd_data  = mem_data_i;
          next_rd_valid = 1'b1;
        end
      end
      ST_RESP: begin
        // The core still holds its request while the answer stands; taking it
        // again here would issue a second array read for one instruction
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Clock enable low holds the whole read path, pulses included
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state        <= ST_IDLE;
      rd_data_o    <= DATA_RST;
      rd_valid_o   <= 1'b0;
      rd_blocked_o <= 1'b0;
    end else if (clk_en_i) begin
      state        <= next_state;
      rd_data_o    <= next_rd_data;
      rd_valid_o   <= next_rd_valid;
      rd_blocked_o <= next_rd_blocked;
    end
  end

  // Erase address decode
  assign is_sec      = (dbg_erase_addr_i == SEC_LO) || (dbg_erase_addr_i == SEC_HI);
  assign in_sec_page = (dbg_erase_addr_i[ADDR_W-1:`PRL_PAGE_SHIFT] == SECPG);
  assign in_rsv      = (dbg_erase_addr_i >= RSV);
  assign page_base   = {dbg_erase_addr_i[ADDR_W-1:`PRL_PAGE_SHIFT], PG_OFS};

  // Security page erase wipes the lock bytes too, so both restore the lock bits
  assign erase_unlock = dbg_erase_i & (is_sec | in_sec_page);
  // Debug erase wins over a clear in the same cycle
  assign fw_clear     = lock_clr_i & ~dbg_erase_i;
  // No firmware path ever sets a bit back, so lock_set_i is left unused
  assign lock_rdata_o = lock;

  // Per bit: a clear writes 0 where the data bit is 0, never a 1
  genvar gi;
  generate
    for (gi = 0; gi < LOCK_W; gi = gi + 1) begin : g_lock
      assign next_lock[gi] = erase_unlock ? 1'b1 :
                             (fw_clear & ~lock_wdata_i[gi]) ? 1'b0 :
                             lock[gi];
    end
  endgenerate

  // Erase priority: security byte, security page, reserved area, plain page
  always @* begin
    next_erase_all  = 1'b0;
    next_erase_page = 1'b0;
    next_erase_err  = 1'b0;
    next_page_addr  = erase_page_addr_o;
    if (dbg_erase_i && is_sec) begin
      next_erase_all = 1'b1;
    end else if (dbg_erase_i && in_sec_page) begin
      next_erase_page = 1'b1;
      next_page_addr  = page_base;
    end else if (dbg_erase_i && in_rsv) begin
      // Reserved area is never the target of a page erase
      next_erase_err = 1'b1;
    end else if (dbg_erase_i) begin
      next_erase_page = 1'b1;
      next_page_addr  = page_base;
    end
  end

  // Lock bits and erase pulses
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lock              <= LOCK_RST;
      erase_all_o       <= 1'b0;
      erase_page_o      <= 1'b0;
      erase_page_addr_o <= ADDR_RST;
      erase_err_o       <= 1'b0;
    end else if (clk_en_i) begin
      lock              <= next_lock;
      erase_all_o       <= next_erase_all;
      erase_page_o      <= next_erase_page;
      erase_page_addr_o <= next_page_addr;
      erase_err_o       <= next_erase_err;
    end
  end

endmodule // prl_read_limit
